// File: shared/tsdp_pkg.sv
/*
  Shared constants for the two-bit sensor drive port: register addresses,
  field positions, reset values and pin numbering.
  Assumes an 8-bit register address and 8-bit register data.
*/
package tsdp_pkg;

  // Port width
  localparam int PIN_COUNT = 2;

  // Register addresses
  localparam logic [7:0] ADDR_OUT_DIR = 8'h40;
  localparam logic [7:0] ADDR_PIN_LEVELS = 8'h41;
  localparam logic [7:0] ADDR_MODE = 8'h70;

  // Field positions in the output/direction register
  localparam int OUT_DATA_LSB = 0;
  localparam int DIR_LSB = 4;

  // Field positions in the mode register
  localparam int MODE_REF_IN_BIT = 0;
  localparam int MODE_REF_OUT_BIT = 1;

  // Pin numbering of the analog functions
  localparam int REF_OUT_PIN = 0;
  localparam int REF_IN_PIN = 1;

  // Implemented bits of the output/direction register, others read zero
  localparam logic [7:0] OUT_DIR_MASK = 8'h33;

  // Reset values: both pins driving, both driving low, all pins digital
  localparam logic [7:0] OUT_DIR_RESET = 8'h30;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Value returned for unmapped reads
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // True when the mode byte hands pin idx over to an analog function
  function automatic logic pinIsAnalog(input logic [7:0] mode, input int idx);
    logic hit;
    hit = 1'b0;
    if (idx == REF_OUT_PIN) begin
      hit = mode[MODE_REF_OUT_BIT];
    end else if (idx == REF_IN_PIN) begin
      hit = mode[MODE_REF_IN_BIT];
    end
    return hit;
  endfunction

endpackage

// File: hw/tsdp_pin_cell.sv
/*
  One pad control cell of the sensor drive port: registers the drive value
  and the active-low output enable of a single pin.
  Assumes the caller supplies the stored data, direction and analog override.
*/
`timescale 1ns/1ps
module tsdp_pin_cell
  import tsdp_pkg::*;
(
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Settings for this pin
  input wire logic dataBit,
  input wire logic dirBit,
  input wire logic analogSel,
  // Pad controls
  output logic padOut,
  output logic padOeN
);

  logic padOut_q, padOut_d; // Registered drive level
  logic padOeN_q, padOeN_d; // Registered enable, low while driving

  // Next pad state: drive only when an output and not handed to analog
  always_comb begin
    padOut_d = padOut_q;
    padOeN_d = padOeN_q;
    if (ce) begin
      padOut_d = dataBit;
      padOeN_d = ~(dirBit & ~analogSel);
    end
  end

  // Pad registers; reset state matches a driving-low output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      padOut_q <= OUT_DIR_RESET[OUT_DATA_LSB];
      padOeN_q <= ~OUT_DIR_RESET[DIR_LSB];
    end else begin
      padOut_q <= padOut_d;
      padOeN_q <= padOeN_d;
    end
  end

  assign padOut = padOut_q;
  assign padOeN = padOeN_q;

endmodule // tsdp_pin_cell

// File: hw/tsdp_port.sv
/*
  Two-bit sensor drive port: output/direction, pin level and mode registers,
  pad control for two pins and the analog reference handover.
  Assumes a synchronous single-cycle register port and pin inputs already
  synchronous to mclk; the pad wire itself is resolved outside.
*/
`timescale 1ns/1ps
module tsdp_port
  import tsdp_pkg::*;
(
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register access port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Port pins
  input wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOeN,
  // Analog reference switch controls
  output logic refOutEn,
  output logic refInEn
);

  logic [7:0] outDir_q, outDir_d; // Output/direction register
  logic [7:0] mode_q, mode_d; // Operating mode register
  logic [7:0] rdData_q, rdData_d; // Read data holding register
  logic rdValid_q, rdValid_d; // Read answer strobe
  logic refOut_q, refOut_d; // Reference output switch
  logic refIn_q, refIn_d; // Reference input switch
  logic [PIN_COUNT-1:0] dataBits; // Stored drive levels
  logic [PIN_COUNT-1:0] dirBits; // Stored directions
  logic [PIN_COUNT-1:0] analogBits; // Per-pin analog override

  // Field extraction, bit i of each field belongs to pin i
  assign dataBits = outDir_q[OUT_DATA_LSB +: PIN_COUNT];
  assign dirBits = outDir_q[DIR_LSB +: PIN_COUNT];

  // Register writes; the pin level address has no storage
  always_comb begin
    outDir_d = outDir_q;
    mode_d = mode_q;
    // A write is taken only on an enabled edge
    if (ce && regWrEn) begin
      unique case (regAddr)
        ADDR_OUT_DIR: begin
          outDir_d = regWrData & OUT_DIR_MASK;
        end
        ADDR_MODE: begin
          mode_d = regWrData;
        end
        default: begin
          // Pin level and unmapped addresses: write is dropped
          outDir_d = outDir_q;
        end
      endcase
    end
  end

  // Configuration registers with power-on defaults
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outDir_q <= OUT_DIR_RESET;
      mode_q <= MODE_RESET;
    end else begin
      outDir_q <= outDir_d;
      mode_q <= mode_d;
    end
  end

  // Read mux; pin levels come straight from the pad inputs
  always_comb begin
    rdData_d = rdData_q;
    rdValid_d = rdValid_q;
    if (ce) begin
      // Strobe answers every accepted read, one edge later
      rdValid_d = regRdEn;
      if (regRdEn) begin
        unique case (regAddr)
          ADDR_OUT_DIR: begin
            rdData_d = outDir_q;
          end
          ADDR_PIN_LEVELS: begin
            rdData_d = {{(8-PIN_COUNT){1'b0}}, pinIn};
          end
          ADDR_MODE: begin
            rdData_d = mode_q;
          end
          default: begin
            rdData_d = READ_UNMAPPED;
          end
        endcase
      end
    end
  end

  // Read answer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= READ_UNMAPPED;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // Analog switch controls follow the mode bits
  always_comb begin
    refOut_d = refOut_q;
    refIn_d = refIn_q;
    if (ce) begin
      // Switches trail the mode register by one edge, like the pads
      refOut_d = mode_q[MODE_REF_OUT_BIT];
      refIn_d = mode_q[MODE_REF_IN_BIT];
    end
  end

  // Analog switch registers, both off from reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refOut_q <= MODE_RESET[MODE_REF_OUT_BIT];
      refIn_q <= MODE_RESET[MODE_REF_IN_BIT];
    end else begin
      refOut_q <= refOut_d;
      refIn_q <= refIn_d;
    end
  end

  // One pad cell per pin, each with its own override bit
  for (genvar i = 0; i < PIN_COUNT; i++) begin : gPin
    // Pin index doubles as the bit index of the data and direction fields only
    assign analogBits[i] = pinIsAnalog(mode_q, i);
    tsdp_pin_cell uCell (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .dataBit(dataBits[i]),
      .dirBit(dirBits[i]),
      .analogSel(analogBits[i]),
      .padOut(pinOut[i]),
      .padOeN(pinOeN[i])
    );
  end

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign refOutEn = refOut_q;
  assign refInEn = refIn_q;

  // Checks on pad behaviour and the register file

  // Output pin not in analog use drives its data bit
  chk_pin0_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && dirBits[0] && !analogBits[0]) |=> (!pinOeN[0] && pinOut[0] == $past(dataBits[0])))
    else $error("pin zero not driving its data");

  chk_pin1_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && dirBits[1] && !analogBits[1]) |=> (!pinOeN[1] && pinOut[1] == $past(dataBits[1])))
    else $error("pin one not driving its data");

  // Input-only pin releases its driver
  chk_input_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !dirBits[0]) |=> pinOeN[0])
    else $error("input-only pin still driving");

  // Analog override releases the digital driver and closes the switch
  chk_ref_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && mode_q[MODE_REF_OUT_BIT]) |=> (pinOeN[REF_OUT_PIN] && refOutEn))
    else $error("reference output did not take pin zero");

  chk_ref_in: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && mode_q[MODE_REF_IN_BIT] && !mode_q[MODE_REF_OUT_BIT] && dirBits[0])
    |=> (pinOeN[REF_IN_PIN] && refInEn && !pinOeN[REF_OUT_PIN]))
    else $error("reference input override wrong");

  // Pin level read returns the pins sampled at the request
  chk_level_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regRdEn && regAddr == ADDR_PIN_LEVELS)
    |=> (regRdValid && regRdData == {{(8-PIN_COUNT){1'b0}}, $past(pinIn)}))
    else $error("pin level read mismatch");

  // Write to the pin level address leaves the stored registers alone
  chk_level_ro: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regWrEn && regAddr == ADDR_PIN_LEVELS) |=> ($stable(outDir_q) && $stable(mode_q)))
    else $error("write to read-only register changed state");

  // Direction write lands and reads back masked
  chk_dir_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regWrEn && regAddr == ADDR_OUT_DIR) ##1 (ce && regRdEn && regAddr == ADDR_OUT_DIR && !regWrEn)
    |=> regRdData == ($past(regWrData, 2) & OUT_DIR_MASK))
    else $error("output/direction readback wrong");

  // Frozen while enable low
  chk_freeze: assert property (@(posedge mclk) disable iff (!rst_n)
    !ce |=> ($stable(outDir_q) && $stable(pinOeN) && $stable(regRdValid)))
    else $error("state changed with enable low");

  // Reset defaults: all pins driving low
  chk_reset_val: assert property (@(posedge mclk)
    $rose(rst_n) |-> (dirBits == '1 && dataBits == '0 && pinOeN == '0))
    else $error("reset defaults wrong");

  // Input-only pin one releases its driver too
  chk_pin1_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !dirBits[1]) |=> pinOeN[1])
    else $error("input-only pin one still driving");

  // Drive levels follow the data field even while a pin is released
  chk_data_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    ce |=> (pinOut == $past(dataBits)))
    else $error("drive level does not follow data field");

  // Each switch follows its own mode bit, in all four combinations
  chk_switch_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    ce |=> (refOutEn == $past(mode_q[MODE_REF_OUT_BIT]) && refInEn == $past(mode_q[MODE_REF_IN_BIT])))
    else $error("reference switch does not follow its mode bit");

  // Reference input takes pin one whatever its direction bit says
  chk_ref_in_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && mode_q[MODE_REF_IN_BIT]) |=> pinOeN[REF_IN_PIN])
    else $error("reference input did not release pin one");

  // A digital pin zero follows its own direction bit alone
  chk_pin0_alone: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !analogBits[0]) |=> (pinOeN[0] == ~$past(dirBits[0])))
    else $error("pin zero enable does not follow its own direction");

  // A digital pin one follows its own direction bit alone
  chk_pin1_alone: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !analogBits[1]) |=> (pinOeN[1] == ~$past(dirBits[1])))
    else $error("pin one enable does not follow its own direction");

  // Unimplemented bits of the output/direction register stay zero
  chk_outdir_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    (outDir_q & ~OUT_DIR_MASK) == 8'h00)
    else $error("unimplemented output/direction bits set");

  // Mode write lands in full
  chk_mode_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regWrEn && regAddr == ADDR_MODE) |=> (mode_q == $past(regWrData)))
    else $error("mode write did not land");

  // Mode register reads back what is stored
  chk_mode_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regRdEn && regAddr == ADDR_MODE) |=> (regRdValid && regRdData == $past(mode_q)))
    else $error("mode readback wrong");

  // Unmapped reads return the fixed filler
  chk_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regRdEn && regAddr != ADDR_OUT_DIR && regAddr != ADDR_PIN_LEVELS && regAddr != ADDR_MODE)
    |=> (regRdData == READ_UNMAPPED))
    else $error("unmapped read not zero");

  // Every accepted read is answered on the next edge
  chk_read_valid: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && regRdEn) |=> regRdValid)
    else $error("read not answered");

  // No answer strobe without an accepted read
  chk_valid_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !regRdEn) |=> !regRdValid)
    else $error("answer strobe without a read");

  // Read data stands until the next read
  chk_data_stands: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !regRdEn) |=> $stable(regRdData))
    else $error("read data changed without a read");

  // Enable low also freezes mode, drive levels, switches and read data
  chk_freeze_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    !ce |=> ($stable(mode_q) && $stable(pinOut) && $stable(refOutEn) && $stable(refInEn) && $stable(regRdData)))
    else $error("mode or outputs changed with enable low");

  // Reset leaves the switches open, the pins low and no answer pending
  chk_reset_switch: assert property (@(posedge mclk)
    $rose(rst_n) |-> (!refOutEn && !refInEn && !regRdValid && pinOut == '0))
    else $error("reset left switches or drive wrong");

  // Main scenarios
  cov_both_analog: cover property (@(posedge mclk) disable iff (!rst_n)
    refOutEn && refInEn);
  cov_mixed_dir: cover property (@(posedge mclk) disable iff (!rst_n)
    !pinOeN[0] && pinOeN[1] && !analogBits[1]);
  cov_readback_drive: cover property (@(posedge mclk) disable iff (!rst_n)
    regRdValid && $past(regAddr) == ADDR_PIN_LEVELS && !pinOeN[0]);
  cov_ro_write: cover property (@(posedge mclk) disable iff (!rst_n)
    ce && regWrEn && regAddr == ADDR_PIN_LEVELS);
  cov_freeze_write: cover property (@(posedge mclk) disable iff (!rst_n)
    !ce && regWrEn);

endmodule // tsdp_port

// File: tb/tsdp_pad_model.sv
/*
  Pad wire model for the two sensor drive pins and the sensors behind them.
  Assumes active-low output enables from the port and the port's mclk.
*/
`timescale 1ns/1ps
module tsdp_pad_model (
  // Clock
  input wire logic mclk,
  // Port side of the pads
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOeN,
  // External sensor drive
  input wire logic [1:0] extVal,
  input wire logic [1:0] extEn,
  // Level seen at the pads
  output logic [1:0] pinIn
);
  logic [1:0] lastQ; // Last resolved level

  // Port driver first, then the sensor; a floating pin flips every cycle
  assign pinIn = (~pinOeN & pinOut) | (pinOeN & extEn & extVal) | (pinOeN & ~extEn & ~lastQ);

  // Remember the level so a floating pin never looks stable
  always_ff @(posedge mclk) begin
    lastQ <= pinIn;
  end
endmodule // tsdp_pad_model

// File: tb/test_two_bit_sensor_drive_port.sv
/*
  Self-checking bench for the two-bit sensor drive port.
  Assumes the pad model resolves the pin wires; ce is low only in the freeze test.
*/
`timescale 1ns/1ps
module test_two_bit_sensor_drive_port
  import tsdp_pkg::*;
;
  logic mclk, rst_n, ce, regWrEn, regRdEn, regRdValid, refOutEn, refInEn;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic [1:0] pinIn, pinOut, pinOeN, extVal, extEn;
  int n_fail, n_compared;

  // Port under test
  tsdp_port DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .refOutEn(refOutEn), .refInEn(refInEn));

  // Pads and sensors
  tsdp_pad_model pads (.mclk(mclk), .pinOut(pinOut), .pinOeN(pinOeN), .extVal(extVal),
    .extEn(extEn), .pinIn(pinIn));

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One register write; returns at the edge that takes it
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask

  // One register read with a bounded wait for the answer
  task rd(input logic [7:0] a);
    int i;
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    i = 0;
    while (regRdValid !== 1'b1 && i < 4) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (i == 4) begin
      n_fail++;
      $display("[ERR] %0t read never answered", $time);
      summarize();
    end
    d = regRdData;
  endtask

  // Pads follow a write one edge after the edge that takes it; wait two edges
  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task t_reset;
    #1;
    chk({6'h00, pinOeN}, 8'h00, "reset enables");
    chk({6'h00, pinOut}, 8'h00, "reset drive");
    chk({6'h00, refOutEn, refInEn}, 8'h00, "reset ref");
    rd(ADDR_OUT_DIR);
    chk(d, 8'h30, "reset outdir");
    rd(ADDR_MODE);
    chk(d, 8'h00, "reset mode");
    $display("test reset done");
  endtask

  task t_drive;
    wr(ADDR_OUT_DIR, 8'h11);
    settle();
    chk({6'h00, pinOeN}, 8'h02, "pin0 only drives");
    chk({6'h00, pinOut}, 8'h01, "drive value");
    rd(ADDR_PIN_LEVELS);
    chk(d & 8'h01, 8'h01, "readback of driven pin");
    @(posedge mclk);
    extEn <= 2'b10;
    extVal <= 2'b10;
    rd(ADDR_PIN_LEVELS);
    chk(d, 8'h03, "input pin level");
    wr(ADDR_OUT_DIR, 8'h21);
    settle();
    chk({6'h00, pinOeN}, 8'h01, "pin1 only drives");
    @(posedge mclk);
    extEn <= 2'b01;
    extVal <= 2'b00;
    rd(ADDR_PIN_LEVELS);
    chk(d, 8'h00, "released pin0 follows sensor");
    $display("test drive done");
  endtask

  task t_regs;
    wr(ADDR_PIN_LEVELS, 8'hFF);
    rd(ADDR_OUT_DIR);
    chk(d, 8'h21, "outdir after level write");
    rd(ADDR_PIN_LEVELS);
    chk(d, 8'h00, "levels after write");
    rd(8'h55);
    chk(d, 8'h00, "unmapped read");
    wr(ADDR_OUT_DIR, 8'hFF);
    rd(ADDR_OUT_DIR);
    chk(d, 8'h33, "outdir implemented bits");
    $display("test regs done");
  endtask

  task t_mode;
    logic [7:0] m;
    @(posedge mclk);
    extEn <= 2'b00;
    for (int i = 0; i < 4; i++) begin
      m = 8'(i);
      wr(ADDR_MODE, m);
      settle();
      chk({6'h00, refOutEn, refInEn}, m, "ref switches");
      chk({6'h00, pinOeN}, {6'h00, m[0], m[1]}, "analog release");
      chk({6'h00, pinOut}, 8'h03, "data kept");
    end
    $display("test mode done");
  endtask

  // Enable low: writes and reads are ignored and the pads hold
  task t_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    wr(ADDR_OUT_DIR, 8'h00);
    wr(ADDR_MODE, 8'h00);
    @(posedge mclk);
    regAddr <= ADDR_MODE;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    settle();
    chk({7'h00, regRdValid}, 8'h00, "no answer while frozen");
    chk({6'h00, pinOeN}, 8'h03, "pads held while frozen");
    chk({6'h00, refOutEn, refInEn}, 8'h03, "switches held while frozen");
    @(posedge mclk);
    ce <= 1'b1;
    rd(ADDR_OUT_DIR);
    chk(d, 8'h33, "outdir kept while frozen");
    rd(ADDR_MODE);
    chk(d, 8'h03, "mode kept while frozen");
    $display("test freeze done");
  endtask

  // Reset in mid-run brings back the power-on defaults
  task t_rerun;
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    chk({6'h00, pinOeN}, 8'h00, "pads driving in reset");
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk({6'h00, pinOut}, 8'h00, "drive low after reset");
    chk({6'h00, refOutEn, refInEn}, 8'h00, "switches open after reset");
    rd(ADDR_OUT_DIR);
    chk(d, OUT_DIR_RESET, "outdir after reset");
    rd(ADDR_MODE);
    chk(d, MODE_RESET, "mode after reset");
    $display("test rerun done");
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    extEn = 2'b00;
    extVal = 2'b00;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_drive();
    t_regs();
    t_mode();
    t_freeze();
    t_rerun();
    summarize();
  end
endmodule // test_two_bit_sensor_drive_port
